// [hdl/mbd_decode.sv]
// Address decoder: area, wait states, frame and guard flags for one bus
`timescale 1ns/1ps
`default_nettype none
module mbd_decode
  import mbd_pkg::*;
(
  input wire logic [31:0] addr,
  input wire logic prog,
  input wire logic we,
  input wire logic [WS_W-1:0] flash_ws,
  input wire logic [WS_W-1:0] otp_ws,
  output mbd_area_t area,
  output logic [WS_W-1:0] ws,
  output logic narrow,
  output logic guarded
);
  // Priority chain over the map; unmapped falls through to AR_NONE
  always_comb begin
    area = AR_NONE;
    ws = WS_ZERO;
    narrow = 1'b0;
    if (in_rng(addr, M0_LO, M0_HI)) begin
      area = AR_M0;
    end else if (in_rng(addr, M1_LO, M1_HI)) begin
      area = AR_M1;
    end else if (!prog && in_rng(addr, PF0_LO, PF0_HI)) begin
      area = AR_PF0;
    end else if (!prog && in_rng(addr, PF1_LO, PF1_HI)) begin
      area = AR_PBUS;
      ws = we ? WS_ZERO : WS_PF_RD;
    end else if (!prog && in_rng(addr, PF2_LO, PF2_HI)) begin
      area = AR_PBUS;
      narrow = 1'b1;
      ws = we ? WS_ZERO : WS_PF_RD;
    end else if (in_rng(addr, L0_LO, L0_HI)) begin
      area = AR_L0;
    end else if (in_rng(addr, L1_LO, L1_HI)) begin
      area = AR_L1;
    end else if (in_rng(addr, OTP_LO, OTP_HI)) begin
      area = AR_OTP;
      ws = (otp_ws < WS_OTP_MIN) ? WS_OTP_MIN : otp_ws;
    end else if (in_rng(addr, FLASH_LO, FLASH_HI)) begin
      // Sectors D..A up to SECT_A_HI, then the security words
      area = AR_FLASH;
      ws = in_rng(addr, PWD_LO, PWD_HI) ? WS_PWD : flash_ws;
    end else if (in_rng(addr, ROM_LO, ROM_HI)) begin
      area = AR_ROM;
      ws = WS_ROM;
    end
  end

  // Guard only matters for writes
  assign guarded = we && (in_rng(addr, GRD0_LO, GRD0_HI) || in_rng(addr, GRD1_LO, GRD1_HI));
endmodule
`default_nettype wire

// [hdl/mbd_fabric.sv]
// Memory bus fabric: arbitration, decode, wait states and peripheral bridge
`timescale 1ns/1ps
`default_nettype none
module mbd_fabric
  import mbd_pkg::*;
#(
  parameter int FWS_W = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire mbd_pr_s pr_req,
  output logic pr_ack,
  output logic [31:0] pr_rdata,
  output logic pr_rvalid,
  input wire mbd_dr_s dr_req,
  output logic dr_ack,
  output logic [31:0] dr_rdata,
  output logic dr_rvalid,
  input wire mbd_dw_s dw_req,
  output logic dw_ack,
  input wire logic [FWS_W-1:0] flash_ws,
  input wire logic [FWS_W-1:0] otp_ws,
  input wire logic prot_cfg_wr,
  input wire logic prot_cfg_val,
  output logic prot_en,
  input wire logic [NAREA-1:0][31:0] area_rdata,
  output mbd_cmd_s [NAREA-1:0] mem_cmd,
  output mbd_pcmd_s pbus_cmd
);
  logic [1:0] rsync_reg;
  logic rst_n;
  logic [NREQ-1:0] rq_v, rq_we, rq_prog, rq_wide, rq_ok, win, ack;
  logic [31:0] rq_addr [NREQ];
  mbd_area_t area [NREQ];
  logic [WS_W-1:0] ws [NREQ];
  logic [NREQ-1:0] narrow, guarded;
  logic [NAREA-1:0] held;
  logic prot_en_reg, prot_en_next;
  logic b2b_reg, b2b_next;
  logic pf1_wr_win, pbus_win;
  mbd_cmd_s [NAREA-1:0] cmd_reg;
  mbd_cmd_s [NAREA-1:0] cmd_next;
  mbd_state_e st_reg [NREQ];
  mbd_area_t tgt_reg [NREQ];
  logic [NREQ-1:0] nar_reg;
  logic [31:0] rd_reg [NREQ];
  logic [NREQ-1:0] rv_reg;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rsync_reg <= 2'b00;
    end else begin
      rsync_reg <= {rsync_reg[0], 1'b1};
    end
  end
  assign rst_n = rsync_reg[1];

  // Normalise the three buses; one write bus means no write clash
  always_comb begin
    rq_v = {pr_req.valid, dr_req.valid, dw_req.valid};
    rq_we = {1'b0, 1'b0, 1'b1};
    rq_prog = {1'b1, 1'b0, dw_req.prog};
    rq_wide = {1'b1, dr_req.wide, dw_req.wide};
    rq_addr[RQ_W] = dw_req.addr;
    rq_addr[RQ_DR] = dr_req.addr;
    rq_addr[RQ_PR] = 32'(pr_req.addr);
  end

  // One decoder per bus so all three decode in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < NREQ; gi++) begin : g_dec
      mbd_decode u_dec (
        .addr(rq_addr[gi]),
        .prog(rq_prog[gi]),
        .we(rq_we[gi]),
        .flash_ws(WS_W'(flash_ws)),
        .otp_ws(WS_W'(otp_ws)),
        .area(area[gi]),
        .ws(ws[gi]),
        .narrow(narrow[gi]),
        .guarded(guarded[gi])
      );
    end
  endgenerate

  // Protection mode: software-set level, on out of reset
  always_comb begin
    prot_en_next = prot_cfg_wr ? prot_cfg_val : prot_en_reg;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prot_en_reg <= 1'b1;
    end else begin
      prot_en_reg <= prot_en_next;
    end
  end
  assign prot_en = prot_en_reg;

  // Eligible requests; a protected read waits for the older write
  always_comb begin
    rq_ok = rq_v;
    if (prot_en_reg && area[RQ_DR] == AR_PBUS && dr_req.wr_older) begin
      rq_ok[RQ_DR] = 1'b0;
    end
  end

  // Resources held by requesters in their data phase
  always_comb begin
    held = '0;
    for (int i = 0; i < NREQ; i++) begin
      if (st_reg[i] == ST_DATA && tgt_reg[i] != AR_NONE) begin
        held[tgt_reg[i]] = 1'b1;
      end
    end
  end

  // Fixed priority per resource; distinct targets all win together
  always_comb begin
    for (int i = 0; i < NREQ; i++) begin
      win[i] = rq_ok[i] && st_reg[i] == ST_IDLE && (area[i] == AR_NONE || !held[area[i]]);
      for (int j = 0; j < i; j++) begin
        if (rq_ok[j] && st_reg[j] == ST_IDLE && area[j] == area[i] && area[i] != AR_NONE) begin
          win[i] = 1'b0;
        end
      end
    end
  end

  // Back-to-back wide-zone writes: flag lives until the bridge goes idle
  always_comb begin
    pf1_wr_win = win[RQ_W] && area[RQ_W] == AR_PBUS && !narrow[RQ_W];
    pbus_win = 1'b0;
    for (int i = 0; i < NREQ; i++) begin
      pbus_win = pbus_win | (win[i] && area[i] == AR_PBUS);
    end
    b2b_next = b2b_reg;
    if (pf1_wr_win) begin
      b2b_next = 1'b1;
    end else if (pbus_win || !held[AR_PBUS]) begin
      b2b_next = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      b2b_reg <= 1'b0;
    end else begin
      b2b_reg <= b2b_next;
    end
  end

  // Per requester: address phase, then a data phase that counts waits
  generate
    for (gi = 0; gi < NREQ; gi++) begin : g_rq
      mbd_state_e st_next;
      logic [WS_W-1:0] cnt_reg, cnt_next;
      mbd_area_t tgt_next;
      logic nar_next, rv_next;
      logic [31:0] rd_next;

      // Ack decodes from state only, so it never loops back through the inputs
      assign ack[gi] = st_reg[gi] == ST_DATA && cnt_reg == WS_ZERO;

      always_comb begin
        st_next = st_reg[gi];
        cnt_next = cnt_reg;
        tgt_next = tgt_reg[gi];
        nar_next = nar_reg[gi];
        rd_next = rd_reg[gi];
        rv_next = 1'b0;
        case (st_reg[gi])
          ST_IDLE: begin
            if (win[gi]) begin
              st_next = ST_DATA;
              tgt_next = area[gi];
              nar_next = narrow[gi];
              cnt_next = ws[gi];
              if (gi == RQ_W && pf1_wr_win && b2b_reg) begin
                cnt_next = ws[gi] + WS_B2B;
              end
            end
          end
          ST_DATA: begin
            if (cnt_reg == WS_ZERO) begin
              st_next = ST_IDLE;
              rv_next = 1'b1;
              // Unmapped reads give zero; narrow zone gives low half only
              if (tgt_reg[gi] == AR_NONE) begin
                rd_next = '0;
              end else if (nar_reg[gi]) begin
                rd_next = {16'h0000, area_rdata[tgt_reg[gi]][15:0]};
              end else begin
                rd_next = area_rdata[tgt_reg[gi]];
              end
            end else begin
              cnt_next = cnt_reg - WS_W'(1);
            end
          end
          default: begin
            st_next = ST_IDLE;
          end
        endcase
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          st_reg[gi] <= ST_IDLE;
          cnt_reg <= WS_ZERO;
          tgt_reg[gi] <= AR_NONE;
          nar_reg[gi] <= 1'b0;
          rd_reg[gi] <= '0;
          rv_reg[gi] <= 1'b0;
        end else begin
          st_reg[gi] <= st_next;
          cnt_reg <= cnt_next;
          tgt_reg[gi] <= tgt_next;
          nar_reg[gi] <= nar_next;
          rd_reg[gi] <= rd_next;
          rv_reg[gi] <= rv_next;
        end
      end
    end
  endgenerate

  // Area commands: loaded at grant, dropped when the owner finishes
  always_comb begin
    cmd_next = cmd_reg;
    for (int i = 0; i < NREQ; i++) begin
      if (ack[i] && tgt_reg[i] != AR_NONE) begin
        cmd_next[tgt_reg[i]].en = 1'b0;
      end
    end
    for (int i = 0; i < NREQ; i++) begin
      if (win[i] && area[i] != AR_NONE) begin
        // Guarded write without allow completes but never reaches the area
        cmd_next[area[i]].en = !(guarded[i] && !(i == RQ_W && dw_req.allow));
        cmd_next[area[i]].we = rq_we[i];
        cmd_next[area[i]].wide = rq_wide[i] && !narrow[i];
        cmd_next[area[i]].narrow_frame = narrow[i];
        cmd_next[area[i]].addr = rq_addr[i][MEM_AW-1:0];
        cmd_next[area[i]].wdata = (i == RQ_W) ? dw_req.data : 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
    end
  end
  assign mem_cmd = cmd_reg;

  // Bridge view of the shared peripheral slot
  always_comb begin
    pbus_cmd.en = cmd_reg[AR_PBUS].en;
    pbus_cmd.we = cmd_reg[AR_PBUS].we;
    pbus_cmd.wide = cmd_reg[AR_PBUS].wide;
    pbus_cmd.narrow_frame = cmd_reg[AR_PBUS].narrow_frame;
    pbus_cmd.addr = cmd_reg[AR_PBUS].addr[PB_AW-1:0];
    pbus_cmd.wdata = cmd_reg[AR_PBUS].wdata;
  end

  // Bus answers: acks from state, read data and rvalid from flops
  assign dw_ack = ack[RQ_W];
  assign dr_ack = ack[RQ_DR];
  assign pr_ack = ack[RQ_PR];
  assign dr_rdata = rd_reg[RQ_DR];
  assign pr_rdata = rd_reg[RQ_PR];
  assign dr_rvalid = rv_reg[RQ_DR];
  assign pr_rvalid = rv_reg[RQ_PR];

  // Checks on the fabric's decode, grant and command state and its outputs
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence rom_grant_s;
    win[RQ_DR] && area[RQ_DR] == AR_ROM;
  endsequence
  sequence one_wait_s;
    !dr_ack ##1 !dr_ack ##1 dr_ack;
  endsequence
  sequence m0_grant_s;
    win[RQ_PR] && area[RQ_PR] == AR_M0;
  endsequence

  prog_frame_miss_a: assert property (area[RQ_PR] != AR_PF0 && area[RQ_PR] != AR_PBUS)
    else $error("program access reached a peripheral frame");
  prot_read_hold_a: assert property (prot_en_reg && area[RQ_DR] == AR_PBUS && dr_req.wr_older |-> !win[RQ_DR])
    else $error("protected read overtook an older write");
  prot_off_cause_a: assert property ($fell(prot_en_reg) |-> $past(prot_cfg_wr) && !$past(prot_cfg_val))
    else $error("protection dropped without a write");
  guard_drop_a: assert property (win[RQ_W] && guarded[RQ_W] && !dw_req.allow |=> !cmd_reg[$past(area[RQ_W])].en)
    else $error("guarded write reached its area");
  rom_one_wait_a: assert property (rom_grant_s |-> one_wait_s)
    else $error("boot ROM read not acked two cycles after grant");
  sram_zero_wait_a: assert property (m0_grant_s |=> pr_ack ##1 pr_rvalid)
    else $error("SRAM fetch not zero-wait");
  pf1_extra_a: assert property (pf1_wr_win && b2b_reg |=> !dw_ack ##1 dw_ack)
    else $error("second wide-zone write missed its extra cycle");
  otp_min_wait_a: assert property (area[RQ_DR] == AR_OTP |-> ws[RQ_DR] >= WS_OTP_MIN)
    else $error("OTP below one wait state");
  pwd_fixed_wait_a: assert property (area[RQ_DR] == AR_FLASH && in_rng(dr_req.addr, PWD_LO, PWD_HI)
    |-> ws[RQ_DR] == WS_PWD)
    else $error("password access not sixteen waits");
  write_first_a: assert property (rq_ok[RQ_W] && rq_ok[RQ_DR] && st_reg[RQ_W] == ST_IDLE && area[RQ_W] == area[RQ_DR]
    && area[RQ_W] != AR_NONE |-> !win[RQ_DR])
    else $error("data read beat a write to the same resource");
  narrow_only_16_a: assert property (pbus_cmd.en && pbus_cmd.narrow_frame |-> !pbus_cmd.wide)
    else $error("32-bit access on the narrow zone");
  unmapped_zero_a: assert property (dr_ack && tgt_reg[RQ_DR] == AR_NONE |=> dr_rvalid && dr_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");
endmodule
`default_nettype wire

// [hdl/mbd_pkg.sv]
// Constants, address map and carrier types of the memory bus fabric
package mbd_pkg;
  // Requesters, highest priority first
  localparam int NREQ = 3;
  localparam int RQ_W = 0;
  localparam int RQ_DR = 1;
  localparam int RQ_PR = 2;

  // Area codes; AR_PBUS is the shared wide/narrow peripheral bridge
  localparam int NAREA = 10;
  typedef logic [3:0] mbd_area_t;
  localparam mbd_area_t AR_NONE = 4'h0;
  localparam mbd_area_t AR_M0 = 4'h1;
  localparam mbd_area_t AR_M1 = 4'h2;
  localparam mbd_area_t AR_L0 = 4'h3;
  localparam mbd_area_t AR_L1 = 4'h4;
  localparam mbd_area_t AR_PF0 = 4'h5;
  localparam mbd_area_t AR_PBUS = 4'h6;
  localparam mbd_area_t AR_OTP = 4'h7;
  localparam mbd_area_t AR_FLASH = 4'h8;
  localparam mbd_area_t AR_ROM = 4'h9;

  // Address map (word addresses)
  localparam logic [31:0] M0_LO = 32'h0000_0000;
  localparam logic [31:0] M0_HI = 32'h0000_03FF;
  localparam logic [31:0] M1_LO = 32'h0000_0400;
  localparam logic [31:0] M1_HI = 32'h0000_07FF;
  localparam logic [31:0] PF0_LO = 32'h0000_0800;
  localparam logic [31:0] PF0_HI = 32'h0000_0FFF;
  localparam logic [31:0] PF1_LO = 32'h0000_6000;
  localparam logic [31:0] PF1_HI = 32'h0000_6FFF;
  localparam logic [31:0] PF2_LO = 32'h0000_7000;
  localparam logic [31:0] PF2_HI = 32'h0000_7FFF;
  localparam logic [31:0] L0_LO = 32'h0000_8000;
  localparam logic [31:0] L0_HI = 32'h0000_8FFF;
  localparam logic [31:0] L1_LO = 32'h0000_9000;
  localparam logic [31:0] L1_HI = 32'h0000_9FFF;
  localparam logic [31:0] OTP_LO = 32'h003D_7800;
  localparam logic [31:0] OTP_HI = 32'h003D_7BFF;
  localparam logic [31:0] FLASH_LO = 32'h003E_8000;
  localparam logic [31:0] SECT_A_HI = 32'h003F_7F7F;
  localparam logic [31:0] FLASH_HI = 32'h003F_7FFF;
  localparam logic [31:0] PWD_LO = 32'h003F_7FF8;
  localparam logic [31:0] PWD_HI = 32'h003F_7FFF;
  localparam logic [31:0] ROM_LO = 32'h003F_F000;
  localparam logic [31:0] ROM_HI = 32'h003F_FFFF;
  // Ranges that need the write-allow condition
  localparam logic [31:0] GRD0_LO = 32'h0000_0880;
  localparam logic [31:0] GRD0_HI = 32'h0000_09FF;
  localparam logic [31:0] GRD1_LO = 32'h0000_6000;
  localparam logic [31:0] GRD1_HI = 32'h0000_60FF;

  // Wait states
  localparam int WS_W = 5;
  localparam logic [4:0] WS_ZERO = 5'h00;
  localparam logic [4:0] WS_PF_RD = 5'h02;
  localparam logic [4:0] WS_ROM = 5'h01;
  localparam logic [4:0] WS_OTP_MIN = 5'h01;
  localparam logic [4:0] WS_PWD = 5'h10;
  localparam logic [4:0] WS_B2B = 5'h01;

  localparam int PR_AW = 22;
  localparam int PB_AW = 16;
  localparam int MEM_AW = 22;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_DATA = 2'b10} mbd_state_e;

  typedef struct packed {
    logic valid;
    logic [PR_AW-1:0] addr;
  } mbd_pr_s;

  typedef struct packed {
    logic valid;
    logic wide;
    logic wr_older;
    logic [31:0] addr;
  } mbd_dr_s;

  typedef struct packed {
    logic valid;
    logic prog;
    logic allow;
    logic wide;
    logic [31:0] addr;
    logic [31:0] data;
  } mbd_dw_s;

  typedef struct packed {
    logic en;
    logic we;
    logic wide;
    logic narrow_frame;
    logic [MEM_AW-1:0] addr;
    logic [31:0] wdata;
  } mbd_cmd_s;

  typedef struct packed {
    logic en;
    logic we;
    logic wide;
    logic narrow_frame;
    logic [PB_AW-1:0] addr;
    logic [31:0] wdata;
  } mbd_pcmd_s;

  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage

// [test/mbd_cpu_model.sv]
// CPU-side requester model for the program, data-read and data-write buses
`timescale 1ns/1ps
`default_nettype none
module mbd_cpu_model
  import mbd_pkg::*;
(
  input wire logic mclk,
  output var mbd_pr_s pr_req,
  input wire logic pr_ack,
  input wire logic [31:0] pr_rdata,
  input wire logic pr_rvalid,
  output var mbd_dr_s dr_req,
  input wire logic dr_ack,
  input wire logic [31:0] dr_rdata,
  input wire logic dr_rvalid,
  output var mbd_dw_s dw_req,
  input wire logic dw_ack
);
  localparam int MAX_WAIT = 64;

  // All buses idle until the bench asks for traffic
  initial begin
    pr_req = '0;
    dr_req = '0;
    dw_req = '0;
  end

  // Bounded wait for the ack of one bus; a hang ends the run
  task automatic wait_ack(input int bus, output int n);
    logic ack;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      ack = (bus == RQ_PR) ? pr_ack : (bus == RQ_DR) ? dr_ack : dw_ack;
      if (n > MAX_WAIT)
        tb_top.hang();
    end while (ack !== 1'b1);
  endtask

  // Fetches and program reads share one bus, so they never coincide
  task automatic rd_pr(input logic [PR_AW-1:0] a, output int n, output logic [31:0] d);
    pr_req <= '{valid: 1'b1, addr: a};
    wait_ack(RQ_PR, n);
    // Released lines show the inverse, never a held copy
    pr_req <= '{valid: 1'b0, addr: ~a};
    @(posedge mclk);
    d = (pr_rvalid === 1'b1) ? pr_rdata : 32'hXXXX_XXXX;
  endtask

  // Data read held with its fields until ack
  task automatic rd_dr(input logic [31:0] a, input logic wide, input logic older, output int n,
                       output logic [31:0] d);
    dr_req <= '{valid: 1'b1, wide: wide, wr_older: older, addr: a};
    wait_ack(RQ_DR, n);
    dr_req <= '{valid: 1'b0, wide: ~wide, wr_older: ~older, addr: ~a};
    @(posedge mclk);
    d = (dr_rvalid === 1'b1) ? dr_rdata : 32'hXXXX_XXXX;
  endtask

  // Older write has gone out; the held read may now proceed
  task automatic clear_older();
    dr_req.wr_older <= 1'b0;
  endtask

  // One write bus with a space flag: data and program writes never coincide
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic prog, input logic allow,
                    input logic wide, input logic keep, output int n);
    dw_req <= '{valid: 1'b1, prog: prog, allow: allow, wide: wide, addr: a, data: d};
    wait_ack(RQ_W, n);
    // Keep leaves valid up so the next write follows without a gap
    if (!keep) begin
      dw_req <= '{valid: 1'b0, prog: ~prog, allow: ~allow, wide: ~wide, addr: ~a, data: ~d};
      @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the memory bus fabric
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mbd_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  mbd_pr_s pr_req;
  mbd_dr_s dr_req;
  mbd_dw_s dw_req;
  logic pr_ack, pr_rvalid, dr_ack, dr_rvalid, dw_ack, prot_en;
  logic [31:0] pr_rdata, dr_rdata;
  logic [3:0] flash_ws = 4'h0;
  logic [3:0] otp_ws = 4'h0;
  logic prot_cfg_wr = 1'b0;
  logic prot_cfg_val = 1'b1;
  logic [NAREA-1:0][31:0] area_rdata;
  mbd_cmd_s [NAREA-1:0] mem_cmd, snap;
  mbd_pcmd_s pbus_cmd, snap_pb;
  int bad_count = 0;
  int n_checks = 0;
  localparam logic [31:0] RD_ADDR [13] = '{32'h0000_0010, 32'h0000_07FF, 32'h0000_0800, 32'h0000_8000,
    32'h0000_9FFF, 32'h0000_6100, 32'h0000_7FFF, 32'h003F_F000, 32'h003D_7800, 32'h003E_8000,
    32'h003F_7F7F, 32'h003F_7FF8, 32'h0000_1000};
  localparam mbd_area_t RD_AREA [13] = '{AR_M0, AR_M1, AR_PF0, AR_L0, AR_L1, AR_PBUS, AR_PBUS, AR_ROM,
    AR_OTP, AR_FLASH, AR_FLASH, AR_FLASH, AR_NONE};
  localparam logic [21:0] PR_ADDR [4] = '{22'h00_0800, 22'h00_7000, 22'h3F_4000, 22'h00_9000};
  localparam mbd_area_t PR_AREA [4] = '{AR_NONE, AR_NONE, AR_FLASH, AR_L1};

  always #4 mclk = ~mclk;

  mbd_fabric dut (.mclk, .rstn, .pr_req, .pr_ack, .pr_rdata, .pr_rvalid, .dr_req, .dr_ack, .dr_rdata,
    .dr_rvalid, .dw_req, .dw_ack, .flash_ws, .otp_ws, .prot_cfg_wr, .prot_cfg_val, .prot_en,
    .area_rdata, .mem_cmd, .pbus_cmd);
  mbd_cpu_model cpu (.mclk, .pr_req, .pr_ack, .pr_rdata, .pr_rvalid, .dr_req, .dr_ack, .dr_rdata,
    .dr_rvalid, .dw_req, .dw_ack);

  // Distinct read word per area so a wrong route shows
  function automatic logic [31:0] pat(input int i);
    return 32'h5A00_0000 + 32'h0001_0101 * 32'(i);
  endfunction

  always_comb
    for (int i = 0; i < NAREA; i++)
      area_rdata[i] = pat(i);

  // Commands as they stand in the ack cycle
  always @(posedge mclk)
    if (pr_ack || dr_ack || dw_ack) begin
      snap <= mem_cmd;
      snap_pb <= pbus_cmd;
    end

  // Read wait states expected for an area
  function automatic int rd_ws(input mbd_area_t ar, input logic [31:0] a);
    case (ar)
      AR_PBUS: return 2;
      AR_ROM: return 1;
      AR_OTP: return (otp_ws == 4'h0) ? 1 : int'(otp_ws);
      AR_FLASH: return (a >= PWD_LO) ? 16 : int'(flash_ws);
      default: return 0;
    endcase
  endfunction

  // Narrow frame returns only the low half; unmapped returns zero
  function automatic logic [31:0] exp_rd(input mbd_area_t ar, input logic [31:0] a);
    if (ar == AR_NONE)
      return 32'h0;
    if (ar == AR_PBUS && a[15:12] == 4'h7)
      return pat(int'(ar)) & 32'h0000_FFFF;
    return pat(int'(ar));
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    test_done();
  endtask

  task automatic set_prot(input logic v);
    prot_cfg_val <= v;
    prot_cfg_wr <= 1'b1;
    @(posedge mclk);
    prot_cfg_wr <= 1'b0;
    @(posedge mclk);
    chk(32'(prot_en), 32'(v));
  endtask

  initial begin
    int n, nw, nd, np;
    logic [31:0] d, dp, a, v;
    mbd_area_t ar;
    void'($urandom(99));
    repeat (2) @(posedge mclk);
    chk(32'({prot_en, dr_ack, dr_rvalid}), 32'h4);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    // Map sweep: wait settings at both ends, then random
    for (int r = 0; r < 4; r++) begin
      flash_ws <= (r == 0) ? 4'h0 : (r == 1) ? 4'hF : 4'($urandom);
      otp_ws <= (r == 0) ? 4'h0 : (r == 1) ? 4'hF : 4'($urandom);
      @(posedge mclk);
      for (int i = 0; i < 13; i++) begin
        ar = RD_AREA[i];
        cpu.rd_dr(RD_ADDR[i], 1'b1, 1'b0, n, d);
        chk(32'(n), 32'(2 + rd_ws(ar, RD_ADDR[i])));
        chk(d, exp_rd(ar, RD_ADDR[i]));
        chk(32'(snap[ar].en), 32'(ar != AR_NONE));
      end
    end
    // Program bus: frames read as empty, flash and SRAM as in data space
    for (int i = 0; i < 4; i++) begin
      cpu.rd_pr(PR_ADDR[i], n, d);
      chk(32'(n), 32'(2 + rd_ws(PR_AREA[i], {10'h0, PR_ADDR[i]})));
      chk(d, exp_rd(PR_AREA[i], {10'h0, PR_ADDR[i]}));
      chk(32'(snap[AR_PF0].en | snap[AR_PBUS].en), 32'h0);
    end
    // Random low SRAM writes, both spaces
    for (int i = 0; i < 8; i++) begin
      a = 32'($urandom_range(32'h3FF));
      v = $urandom;
      cpu.wr(a, v, 1'(i), 1'b0, 1'b1, 1'b0, n);
      chk(32'(n), 32'h2);
      chk(snap[AR_M0].wdata, v);
      chk(32'({snap[AR_M0].we, snap[AR_M0].addr}), {9'h0, 1'b1, a[21:0]});
    end
    // Guarded ranges accept a write only with write-allow
    for (int i = 0; i < 4; i++) begin
      ar = i[1] ? AR_PBUS : AR_PF0;
      cpu.wr(i[1] ? 32'h0000_60FF : 32'h0000_0880, 32'h1234_5678, 1'b0, i[0], 1'b1, 1'b0, n);
      chk(32'(n), 32'h2);
      chk(32'(snap[ar].en), 32'(i[0]));
    end
    // Wide frame keeps the width, narrow frame forces 16-bit
    cpu.wr(32'h0000_6200, 32'hA1B2_C3D4, 1'b0, 1'b0, 1'b1, 1'b0, n);
    chk(32'({snap_pb.wide, snap_pb.narrow_frame, snap_pb.addr}), 32'h0002_6200);
    chk(snap_pb.wdata, 32'hA1B2_C3D4);
    cpu.wr(32'h0000_7204, 32'hA1B2_C3D4, 1'b0, 1'b0, 1'b1, 1'b0, n);
    chk(32'({snap_pb.wide, snap_pb.narrow_frame, snap_pb.addr}), 32'h0001_7204);
    // Back-to-back wide-frame writes: the second pays one cycle
    cpu.wr(32'h0000_6300, 32'h1, 1'b0, 1'b0, 1'b1, 1'b1, n);
    cpu.wr(32'h0000_6304, 32'h2, 1'b0, 1'b0, 1'b1, 1'b0, nw);
    chk(32'(n), 32'h2);
    chk(32'(nw), 32'h3);
    // Three buses on distinct blocks finish together
    fork
      cpu.rd_pr(22'h00_8010, np, dp);
      cpu.rd_dr(32'h0000_0010, 1'b0, 1'b0, nd, d);
      cpu.wr(32'h0000_9010, 32'h5, 1'b1, 1'b0, 1'b0, 1'b0, nw);
    join
    chk(32'(np), 32'h2);
    chk(32'(nd), 32'h2);
    chk(32'(nw), 32'h2);
    chk(dp, pat(3));
    chk(d, pat(1));
    // One block wanted by all three: write, data read, program read
    fork
      cpu.wr(32'h0000_0020, 32'h7, 1'b0, 1'b0, 1'b0, 1'b0, nw);
      cpu.rd_dr(32'h0000_0021, 1'b0, 1'b0, nd, d);
      cpu.rd_pr(22'h00_0022, np, dp);
    join
    chk(32'(nw), 32'h2);
    chk(32'(nd), 32'h4);
    chk(32'(np), 32'h6);
    chk(d, pat(1));
    chk(dp, pat(1));
    // Protected frames hold a read behind an older write
    for (int i = 0; i < 2; i++) begin
      fork
        cpu.rd_dr(i ? 32'h0000_7100 : 32'h0000_6100, 1'b0, 1'b1, n, d);
        begin
          repeat (6) @(posedge mclk);
          cpu.clear_older();
        end
      join
      chk(32'(n), 32'hA);
    end
    // Protection off lets the same read straight through
    set_prot(1'b0);
    cpu.rd_dr(32'h0000_6100, 1'b0, 1'b1, n, d);
    chk(32'(n), 32'h4);
    set_prot(1'b1);
    test_done();
  end
endmodule
`default_nettype wire
